// File: gate_cfg_pkg.sv
package gate_cfg_pkg;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 11;
	localparam logic [ADDR_W-1:0] ADDR_DRV_CTRL = 4'h2;
	localparam logic [ADDR_W-1:0] ADDR_HS_CFG = 4'h3;
	localparam logic [ADDR_W-1:0] ADDR_LS_CFG = 4'h4;
	localparam logic [ADDR_W-1:0] ADDR_OCP_CFG = 4'h5;
	localparam int LOCK_LSB = 8;
	localparam int SRC_LSB = 4;
	localparam int SINK_LSB = 0;
	localparam logic [2:0] LOCK_CODE = 3'h6;
	localparam logic [2:0] UNLOCK_CODE = 3'h3;
	localparam logic [3:0] SRC_RESET = 4'hF;
	localparam logic [3:0] SINK_RESET = 4'hF;
	localparam logic [DATA_W-1:0] CTRL_RESET = 11'h000;
	localparam logic [DATA_W-1:0] LS_RESET = 11'h7FF;
	localparam logic [DATA_W-1:0] OCP_RESET = 11'h000;
	localparam logic [DATA_W-1:0] CTRL_EXEMPT_MASK = 11'h007;
	localparam int FAULT_CLR_BIT = 0;
	localparam int BRAKE_BIT = 1;
	localparam int COAST_BIT = 2;
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} reg_req_s;
	typedef struct packed {
		logic [2:0] lock_field;
		logic [3:0] src_code;
		logic [3:0] sink_code;
	} hs_cfg_s;
endpackage : gate_cfg_pkg

// File: cfg_word_reg.sv
`timescale 1ns/100ps
// One configuration word with a per-bit write mask
module cfg_word_reg #(
	parameter int WIDTH = 11,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// Write port
	input wire logic wr_en,
	input wire logic [WIDTH-1:0] wr_mask,
	input wire logic [WIDTH-1:0] wr_data,
	// Stored value
	output logic [WIDTH-1:0] value
);
	logic [WIDTH-1:0] value_q;
	logic [WIDTH-1:0] value_d;

	// Bits clear in the mask keep their old contents
	assign value_d = wr_en ? ((value_q & ~wr_mask) | (wr_data & wr_mask)) : value_q;
	assign value = value_q;

	// Storage
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			value_q <= RESET_VAL;
		end else begin
			value_q <= value_d;
		end
	end
endmodule : cfg_word_reg

// File: hs_gate_cfg_lock.sv
// Decided for this implementation: strobed register access.
`timescale 1ns/100ps
module hs_gate_cfg_lock (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// Register port
	input wire logic [gate_cfg_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [gate_cfg_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [gate_cfg_pkg::DATA_W-1:0] reg_rdata,
	// Configuration outputs
	output gate_cfg_pkg::hs_cfg_s hs_cfg,
	output logic locked,
	output logic fault_clear_pulse,
	output logic brake_cmd,
	output logic coast_cmd,
	output logic [gate_cfg_pkg::DATA_W-1:0] drv_ctrl,
	output logic [gate_cfg_pkg::DATA_W-1:0] ls_cfg,
	output logic [gate_cfg_pkg::DATA_W-1:0] ocp_cfg,
	// Current settings in mA
	output logic [10:0] hs_source_ma,
	output logic [11:0] hs_sink_ma
);
	// Write masks and fills for the storage cells
	localparam logic [gate_cfg_pkg::DATA_W-1:0] ALL_ONES = '1;
	localparam logic [gate_cfg_pkg::DATA_W-1:0] NONE = '0;
	localparam logic [gate_cfg_pkg::DATA_W-1:0] CLR_ONLY =
		{{(gate_cfg_pkg::DATA_W-1){1'b0}}, 1'b1} << gate_cfg_pkg::FAULT_CLR_BIT;

	// Request, lock state and decode
	gate_cfg_pkg::reg_req_s req;
	logic locked_q;
	logic locked_d;
	logic [2:0] lock_wr_code;
	logic code_wr;
	logic hit_ctrl;
	logic hit_hs;
	logic hit_ls;
	logic hit_ocp;
	logic [gate_cfg_pkg::DATA_W-1:0] ctrl_mask;
	logic [gate_cfg_pkg::DATA_W-1:0] ctrl_wdata;
	logic [gate_cfg_pkg::DATA_W-1:0] ctrl_val;
	logic [gate_cfg_pkg::DATA_W-1:0] ls_val;
	logic [gate_cfg_pkg::DATA_W-1:0] ocp_val;

	// High-side codes, read path and current registers
	logic [3:0] src_q;
	logic [3:0] src_d;
	logic [3:0] sink_q;
	logic [3:0] sink_d;
	logic [gate_cfg_pkg::DATA_W-1:0] hs_word;
	logic [gate_cfg_pkg::DATA_W-1:0] rd_mux;
	logic [gate_cfg_pkg::DATA_W-1:0] rdata_q;
	logic fault_clear_q;
	logic [10:0] src_ma_q;
	logic [11:0] sink_ma_q;
	logic [10:0] src_ma_d;
	logic [11:0] sink_ma_d;

	// Address decode
	// Unmapped words match nothing here, so their writes are dropped
	assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
	assign hit_ctrl = req.wr && (req.addr == gate_cfg_pkg::ADDR_DRV_CTRL);
	assign hit_hs = req.wr && (req.addr == gate_cfg_pkg::ADDR_HS_CFG);
	assign hit_ls = req.wr && (req.addr == gate_cfg_pkg::ADDR_LS_CFG) && !locked_q;
	assign hit_ocp = req.wr && (req.addr == gate_cfg_pkg::ADDR_OCP_CFG) && !locked_q;
	assign lock_wr_code = req.wdata[gate_cfg_pkg::LOCK_LSB +: 3];

	// A lock write while locked and an unlock write while unlocked leave the lock state unchanged
	// Lock state moves only on its own exact codes
	always_comb begin
		locked_d = locked_q;
		if (hit_hs) begin
			if (!locked_q && lock_wr_code == gate_cfg_pkg::LOCK_CODE) begin
				locked_d = 1'b1;
			end else if (locked_q && lock_wr_code == gate_cfg_pkg::UNLOCK_CODE) begin
				locked_d = 1'b0;
			end else begin
				locked_d = locked_q;
			end
		end
	end

	// Current codes only change while unlocked; the locking write itself still lands
	assign code_wr = hit_hs && !locked_q;
	assign src_d = code_wr ? req.wdata[gate_cfg_pkg::SRC_LSB +: 4] : src_q;
	assign sink_d = code_wr ? req.wdata[gate_cfg_pkg::SINK_LSB +: 4] : sink_q;

	// Locked: only the command bits of control remain writable
	assign ctrl_mask = locked_q ? gate_cfg_pkg::CTRL_EXEMPT_MASK : ALL_ONES;

	// Fault clear is never stored, so reads and drv_ctrl always show it low
	assign ctrl_wdata = req.wdata & ~CLR_ONLY;

	// Lock field reads as the unlock or lock code so software sees the state
	assign hs_word = {(locked_q ? gate_cfg_pkg::LOCK_CODE : gate_cfg_pkg::UNLOCK_CODE),
		src_q, sink_q};

	// Reads have no side effects, so a read never disturbs the lock or the codes
	// Read select; unmapped addresses read zero
	assign rd_mux = (req.addr == gate_cfg_pkg::ADDR_DRV_CTRL) ? ctrl_val :
		(req.addr == gate_cfg_pkg::ADDR_HS_CFG) ? hs_word :
		(req.addr == gate_cfg_pkg::ADDR_LS_CFG) ? ls_val :
		(req.addr == gate_cfg_pkg::ADDR_OCP_CFG) ? ocp_val : NONE;

	// The control, low-side and OCP words each have their own masked storage cell
	// Locked, the control cell keeps only its exempt bits writable
	cfg_word_reg #(.WIDTH(gate_cfg_pkg::DATA_W), .RESET_VAL(gate_cfg_pkg::CTRL_RESET)) u_ctrl (
		.mclk(mclk),
		.rst_b(rst_b),
		.wr_en(hit_ctrl),
		.wr_mask(ctrl_mask),
		.wr_data(ctrl_wdata),
		.value(ctrl_val)
	);
	cfg_word_reg #(.WIDTH(gate_cfg_pkg::DATA_W), .RESET_VAL(gate_cfg_pkg::LS_RESET)) u_ls (
		.mclk(mclk),
		.rst_b(rst_b),
		.wr_en(hit_ls),
		.wr_mask(ALL_ONES),
		.wr_data(req.wdata),
		.value(ls_val)
	);
	cfg_word_reg #(.WIDTH(gate_cfg_pkg::DATA_W), .RESET_VAL(gate_cfg_pkg::OCP_RESET)) u_ocp (
		.mclk(mclk),
		.rst_b(rst_b),
		.wr_en(hit_ocp),
		.wr_mask(ALL_ONES),
		.wr_data(req.wdata),
		.value(ocp_val)
	);

	// Source code to mA, 50 mA floor on the two lowest codes
	function automatic logic [10:0] src_ma(input logic [3:0] c);
		case (c)
			4'h0, 4'h1: src_ma = 11'd50;
			4'h2: src_ma = 11'd100;
			4'h3: src_ma = 11'd150;
			4'h4: src_ma = 11'd300;
			4'h5: src_ma = 11'd350;
			4'h6: src_ma = 11'd400;
			4'h7: src_ma = 11'd450;
			4'h8: src_ma = 11'd550;
			4'h9: src_ma = 11'd600;
			4'hA: src_ma = 11'd650;
			4'hB: src_ma = 11'd700;
			4'hC: src_ma = 11'd850;
			4'hD: src_ma = 11'd900;
			4'hE: src_ma = 11'd950;
			default: src_ma = 11'd1000;
		endcase
	endfunction : src_ma

	// Sink code to mA, 100 mA floor on the two lowest codes
	function automatic logic [11:0] sink_ma(input logic [3:0] c);
		case (c)
			4'h0, 4'h1: sink_ma = 12'd100;
			4'h2: sink_ma = 12'd200;
			4'h3: sink_ma = 12'd300;
			4'h4: sink_ma = 12'd600;
			4'h5: sink_ma = 12'd700;
			4'h6: sink_ma = 12'd800;
			4'h7: sink_ma = 12'd900;
			4'h8: sink_ma = 12'd1100;
			4'h9: sink_ma = 12'd1200;
			4'hA: sink_ma = 12'd1300;
			4'hB: sink_ma = 12'd1400;
			4'hC: sink_ma = 12'd1700;
			4'hD: sink_ma = 12'd1800;
			4'hE: sink_ma = 12'd1900;
			default: sink_ma = 12'd2000;
		endcase
	endfunction : sink_ma

	// Decode the next codes so the currents move on the same edge as the codes
	assign src_ma_d = src_ma(src_d);
	assign sink_ma_d = sink_ma(sink_d);

	// Lock state and high-side codes
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			locked_q <= 1'b0;
			src_q <= gate_cfg_pkg::SRC_RESET;
			sink_q <= gate_cfg_pkg::SINK_RESET;
		end else begin
			locked_q <= locked_d;
			src_q <= src_d;
			sink_q <= sink_d;
		end
	end

	// Read data is zero outside its slot, so words from several banks can be ORed
	// Read data, decoded currents and the fault clear pulse
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			rdata_q <= NONE;
			fault_clear_q <= 1'b0;
			src_ma_q <= src_ma(gate_cfg_pkg::SRC_RESET);
			sink_ma_q <= sink_ma(gate_cfg_pkg::SINK_RESET);
		end else begin
			rdata_q <= req.rd ? rd_mux : NONE;
			fault_clear_q <= hit_ctrl && req.wdata[gate_cfg_pkg::FAULT_CLR_BIT];
			src_ma_q <= src_ma_d;
			sink_ma_q <= sink_ma_d;
		end
	end

	// Outputs; brake and coast are held levels, only fault clear is a pulse
	assign reg_rdata = rdata_q;
	// The lock field is rebuilt from the state flag rather than stored
	assign hs_cfg = '{lock_field: hs_word[10:8], src_code: src_q, sink_code: sink_q};
	assign locked = locked_q;
	assign fault_clear_pulse = fault_clear_q;
	assign brake_cmd = ctrl_val[gate_cfg_pkg::BRAKE_BIT];
	assign coast_cmd = ctrl_val[gate_cfg_pkg::COAST_BIT];
	assign drv_ctrl = ctrl_val;
	assign ls_cfg = ls_val;
	assign ocp_cfg = ocp_val;
	assign hs_source_ma = src_ma_q;
	assign hs_sink_ma = sink_ma_q;
endmodule : hs_gate_cfg_lock

// File: hs_gate_cfg_lock_asserts.sv
`timescale 1ns/100ps
// Lock state, code storage, read path and fault clear pulse of the bank
module hs_gate_cfg_lock_asserts (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// Register port
	input wire logic [3:0] reg_addr,
	input wire logic [10:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [10:0] reg_rdata,
	// Watched outputs
	input wire gate_cfg_pkg::hs_cfg_s hs_cfg,
	input wire logic locked,
	input wire logic fault_clear_pulse
);
	// Write to the high-side word and the lock pattern it carries
	wire hs_wr = reg_wr && reg_addr == 4'h3;
	wire [2:0] pat = reg_wdata[10:8];
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	// Fault clear must stay one cycle wide, or faults clear twice
	sequence s_clr_wr;
		reg_wr && reg_addr == 4'h2 && reg_wdata[0];
	endsequence
	sequence s_no_clr_wr;
		!(reg_wr && reg_addr == 4'h2 && reg_wdata[0]);
	endsequence
	sequence s_one_pulse;
		fault_clear_pulse ##1 !fault_clear_pulse;
	endsequence
	a_lock_enter: assert property (hs_wr && pat == 3'h6 |=> locked)
		else $error("lock not entered");
	a_free_stay: assert property (!locked && !(hs_wr && pat == 3'h6) |=> !locked)
		else $error("lock entered without lock code");
	a_unlock_code: assert property (hs_wr && pat == 3'h3 |=> !locked)
		else $error("unlock code ignored");
	a_lock_stay: assert property (locked && !(hs_wr && pat == 3'h3) |=> locked)
		else $error("lock left without unlock code");
	a_code_store: assert property (!locked && hs_wr |=> hs_cfg[7:0] == $past(reg_wdata[7:0]))
		else $error("current codes not stored");
	a_codes_kept: assert property (locked && reg_wr |=> $stable(hs_cfg[7:0]))
		else $error("codes changed while locked");
	a_read_word: assert property (reg_rd && reg_addr == 4'h3 |=>
		reg_rdata == {$past(locked) ? 3'h6 : 3'h3, $past(hs_cfg[7:0])})
		else $error("high-side read wrong");
	a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 11'h000)
		else $error("read data outside read slot");
	a_clr_pulse: assert property (s_clr_wr ##1 s_no_clr_wr |-> s_one_pulse)
		else $error("fault clear pulse wrong");
	a_clr_hit: assert property (s_clr_wr |=> fault_clear_pulse)
		else $error("fault clear pulse missing");
	a_clr_only: assert property (s_no_clr_wr |=> !fault_clear_pulse)
		else $error("fault clear pulse without a clear write");
endmodule : hs_gate_cfg_lock_asserts

// File: test_hs_gate_cfg_lock.sv
`timescale 1ns/100ps
// Bench with a behavioural register model checked after every access
module test_hs_gate_cfg_lock;
	logic mclk = 1'b0;
	logic rst_b = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [10:0] reg_wdata = 11'h000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [10:0] reg_rdata, drv_ctrl, ls_cfg, ocp_cfg, hs_source_ma;
	logic [11:0] hs_sink_ma;
	logic locked, fault_clear_pulse, brake_cmd, coast_cmd;
	gate_cfg_pkg::hs_cfg_s hs_cfg;
	int fail_count = 0;
	int checked = 0;
	int seed = 41;
	int lk = 0, src = 15, snk = 15, ctrl = 0, ls = 'h7FF, ocp = 0, p;
	// Current in mA by code
	int smap[16] = '{50,50,100,150,300,350,400,450,550,600,650,700,850,900,950,1000};
	int kmap[16] = '{100,100,200,300,600,700,800,900,1100,1200,1300,1400,1700,1800,1900,2000};
	always #2.5 mclk = ~mclk;
	hs_gate_cfg_lock hs_gate_cfg_lock_i (.mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.hs_cfg(hs_cfg), .locked(locked), .fault_clear_pulse(fault_clear_pulse),
		.brake_cmd(brake_cmd), .coast_cmd(coast_cmd), .drv_ctrl(drv_ctrl), .ls_cfg(ls_cfg),
		.ocp_cfg(ocp_cfg), .hs_source_ma(hs_source_ma), .hs_sink_ma(hs_sink_ma));
	task automatic chk(string n, logic [11:0] s, logic [11:0] e);
		checked++;
		if (s !== e) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic test_done;
		if (fail_count == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : test_done
	function automatic logic [10:0] hsw();
		return {lk ? 3'h6 : 3'h3, 4'(src), 4'(snk)};
	endfunction : hsw
	// Every level output against the model
	task automatic outs;
		chk("locked", locked, lk);
		chk("hs_cfg", hs_cfg, hsw());
		chk("src_ma", hs_source_ma, smap[src]);
		chk("sink_ma", hs_sink_ma, kmap[snk]);
		chk("ctrl", drv_ctrl, ctrl);
		chk("brake_coast", {coast_cmd, brake_cmd}, ctrl[2:1]);
		chk("ls", ls_cfg, ls);
		chk("ocp", ocp_cfg, ocp);
	endtask : outs
	// One write; the model stores under the lock state from before the write, so the locking write still stores its codes
	task automatic wr(logic [3:0] a, logic [10:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
		if (a == 4'h3 && lk == 1 && d[10:8] == 3'h3) lk = 0;
		else if (a == 4'h3 && lk == 0) begin
			lk = (d[10:8] == 3'h6);
			src = d[7:4];
			snk = d[3:0];
		end
		if (a == 4'h2) ctrl = (lk ? (ctrl & 'h7F8) | (d & 'h7) : d) & 'h7FE;
		if (a == 4'h4 && lk == 0) ls = d;
		if (a == 4'h5 && lk == 0) ocp = d;
		#1;
		chk("pulse", fault_clear_pulse, a == 4'h2 && d[0]);
		outs();
	endtask : wr
	// One read; the data stand only in the cycle after the strobe
	task automatic rd(logic [3:0] a);
		int e;
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1;
		e = a == 3 ? hsw() : a == 4 ? ls : a == 5 ? ocp : a == 2 ? ctrl : 0;
		chk("rdata", reg_rdata, e);
	endtask : rd
	initial begin
		repeat (16) @(posedge mclk);
		rst_b <= 1'b1;
		#1;
		outs();
		rd(4'h3);
		rd(4'h9);
		for (p = 0; p < 16; p++) wr(4'h3, {3'h3, 4'(p), 4'(15 - p)});
		// All patterns locked, unlock code last, then all unlocked with lock code last
		wr(4'h3, 11'h6A5);
		for (p = 0; p < 16; p++) begin
			wr(4'h3, {3'(p < 8 ? p ^ 4 : p ^ 1), 8'($random(seed))});
			wr(4'h2, 11'($random(seed)));
			wr(4'h4, 11'($random(seed)));
			wr(4'h5, 11'($random(seed)));
			rd(4'h3);
			rd(4'h4);
		end
		repeat (150) begin
			wr(4'($random(seed)), 11'($random(seed)));
			rd(4'($random(seed)));
		end
		test_done();
	end
	// Cuts a stalled run short
	initial begin
		#100000;
		fail_count++;
		test_done();
	end
endmodule : test_hs_gate_cfg_lock
bind hs_gate_cfg_lock hs_gate_cfg_lock_asserts hs_gate_cfg_lock_asserts_i (.mclk(mclk),
	.rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .hs_cfg(hs_cfg), .locked(locked),
	.fault_clear_pulse(fault_clear_pulse));
